// file: rtl/csw_defs.vh
// Purpose: Constants for the selective wake configuration bank
// Assumes: 7-bit register addresses, 8-bit data
// Notes:   Included by csw_config_bank.v
`ifndef CSW_DEFS_VH
`define CSW_DEFS_VH
`define CSW_ADDR_CTRL      7'h20
`define CSW_ADDR_BTQ       7'h21
`define CSW_ADDR_SPC       7'h22
`define CSW_ADDR_ID_TOP    7'h23
`define CSW_ADDR_ID_UMID   7'h24
`define CSW_ADDR_ID_LMID   7'h25
`define CSW_ADDR_ID_BOT    7'h26
`define CSW_ADDR_MASK_TOP  7'h27
`define CSW_RST_CTRL       8'h00
`define CSW_RST_BTQ        8'ha0
`define CSW_RST_SPC        6'h33
`define CSW_RST_ID         8'h00
`define CSW_RST_BOT        7'h00
`define CSW_BIT_CAL        7
`define CSW_BIT_TRIM_HI    6
`define CSW_BIT_TRIM_LO    5
`define CSW_BIT_TO_MASK    4
`define CSW_BIT_CONFIG_VALID    0
`define CSW_TRIM_UNLOCK    2'h3
`define CSW_BIT_RTR        1
`define CSW_BIT_IDE        0
`endif

// file: rtl/csw_config_bank.v
// Purpose: Selective wake configuration register bank
// Assumes: Serial control port already decoded into wr/rd strobes with address and data
// Notes:   One clock; reads are combinational from flip-flops
// Overview of operation
// - Calibration enable bit 7 turns oscillator calibration mode on or off.
// - Trim unlock field bits 6:5 unlocks calibration only when it holds 11.
// - Unlocked, enabled calibration uses transceiver tx input as trim reference.
// - Wake option register writes accepted only while trim unlock holds 11.
// - Time-out mask bit 4 gates the bus time-out onto the interrupt output.
// - Time-out flag updates only while selective wake is enabled.
// - Reserved bits always read as zero.
// - Host validates config then sets config valid; wake enabled only while set.
// - Config valid clears on wake-up, power-on reset, or config data change.
// - In Stop mode any CAN or wake config write clears config valid.
// - Eight-bit quanta per bit; quantum length set by quantum clock select.
// - Six-bit sample point fraction below one.
// - Expected 29-bit identifier spread over four registers, low bits at 6:2.
// - Extension bit 0 selects standard or extended identifier length.
// - Reset loads bit time 0xa0, sample point 0x33, others zero.
// - Mask bit one compares the identifier bit, zero ignores it.
// - Wake frame matches only when its length code equals the configured one.
`timescale 1ns/100ps
`include "csw_defs.vh"
module csw_config_bank #(
   parameter ID_W = 29
) (
   input  wire            clock,
   input  wire            rst,
   input  wire            soft_rst,
   input  wire            wr_en,
   input  wire            rd_en,
   input  wire [6:0]      addr,
   input  wire [7:0]      wr_data,
   output reg  [7:0]      rd_data,
   input  wire            cfg_write_other,
   input  wire            stop_mode,
   input  wire            normal_mode,
   input  wire            wake_event,
   input  wire            bus_timeout_event,
   input  wire            transceiver_tx_input,
   input  wire            wake_option_wr,
   output wire            wake_option_wr_accept,
   output wire            calibration_active,
   output wire            trim_reference,
   output wire            selective_wake_en,
   output reg             bus_timeout_flag,
   output wire            irq,
   output wire [7:0]      quanta_per_bit,
   output wire [5:0]      sample_point_fraction,
   output wire [ID_W-1:0] expected_id,
   output wire            expected_ide,
   output wire            expected_rtr,
   output wire [7:0]      id_mask_top,
   output wire            cfg_clear_pulse
);
   reg        calibration_enable_r;
   reg [1:0]  trim_unlock_r;
   reg        bus_timeout_irq_enable_r;
   reg        config_valid_r;
   reg [7:0]  btq_r;
   reg [5:0]  spc_r;
   reg [7:0]  id_top_r;
   reg [7:0]  id_umid_r;
   reg [7:0]  id_lmid_r;
   reg [6:0]  id_bot_r;
   reg [7:0]  mask_top_r;
   wire       unlocked;
   wire       wr_ctrl;
   wire       wr_cfg_data;
   wire       config_valid_set;
   wire       config_valid_clr;

   assign unlocked = (trim_unlock_r == `CSW_TRIM_UNLOCK);
   assign calibration_active = calibration_enable_r & unlocked;
   assign trim_reference = calibration_active & transceiver_tx_input;
   assign wake_option_wr_accept = wake_option_wr & unlocked;
   assign wr_ctrl = wr_en & (addr == `CSW_ADDR_CTRL);
   assign wr_cfg_data = (wr_en & (addr >= `CSW_ADDR_BTQ) & (addr <= `CSW_ADDR_MASK_TOP))
                        | cfg_write_other;
   assign cfg_clear_pulse = wr_cfg_data | (stop_mode & (wr_ctrl | wr_cfg_data));
   assign config_valid_set = wr_ctrl & wr_data[`CSW_BIT_CONFIG_VALID] & ~stop_mode;
   assign config_valid_clr = cfg_clear_pulse | wake_event | soft_rst |
                        (wr_ctrl & ~wr_data[`CSW_BIT_CONFIG_VALID]);
   assign selective_wake_en = config_valid_r;
   assign irq = bus_timeout_flag & bus_timeout_irq_enable_r;
   assign quanta_per_bit = btq_r;
   assign sample_point_fraction = spc_r;
   assign expected_id = {id_top_r, id_umid_r, id_lmid_r, id_bot_r[6:2]};
   assign expected_rtr = id_bot_r[`CSW_BIT_RTR];
   assign expected_ide = id_bot_r[`CSW_BIT_IDE];
   assign id_mask_top = mask_top_r;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         calibration_enable_r     <= 1'b0;
         trim_unlock_r            <= 2'h0;
         bus_timeout_irq_enable_r <= 1'b0;
         config_valid_r           <= 1'b0;
         btq_r                    <= `CSW_RST_BTQ;
         spc_r                    <= `CSW_RST_SPC;
         id_top_r                 <= `CSW_RST_ID;
         id_umid_r                <= `CSW_RST_ID;
         id_lmid_r                <= `CSW_RST_ID;
         id_bot_r                 <= `CSW_RST_BOT;
         mask_top_r               <= `CSW_RST_ID;
         bus_timeout_flag         <= 1'b0;
      end else if (soft_rst) begin
         calibration_enable_r     <= 1'b0;
         trim_unlock_r            <= 2'h0;
         bus_timeout_irq_enable_r <= 1'b0;
         config_valid_r           <= 1'b0;
         btq_r                    <= `CSW_RST_BTQ;
         spc_r                    <= `CSW_RST_SPC;
         id_top_r                 <= `CSW_RST_ID;
         id_umid_r                <= `CSW_RST_ID;
         id_lmid_r                <= `CSW_RST_ID;
         id_bot_r                 <= `CSW_RST_BOT;
         mask_top_r               <= `CSW_RST_ID;
         bus_timeout_flag         <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            calibration_enable_r     <= wr_data[`CSW_BIT_CAL];
            trim_unlock_r            <= wr_data[`CSW_BIT_TRIM_HI:`CSW_BIT_TRIM_LO];
            bus_timeout_irq_enable_r <= wr_data[`CSW_BIT_TO_MASK];
         end
         if (config_valid_set & ~cfg_clear_pulse & ~wake_event)
            config_valid_r <= 1'b1;
         else if (config_valid_clr)
            config_valid_r <= 1'b0;
         if (wr_en) begin
            case (addr)
               `CSW_ADDR_BTQ:      btq_r      <= wr_data;
               `CSW_ADDR_SPC:      spc_r      <= wr_data[5:0];
               `CSW_ADDR_ID_TOP:   id_top_r   <= wr_data;
               `CSW_ADDR_ID_UMID:  id_umid_r  <= wr_data;
               `CSW_ADDR_ID_LMID:  id_lmid_r  <= wr_data;
               `CSW_ADDR_ID_BOT:   id_bot_r   <= wr_data[6:0];
               `CSW_ADDR_MASK_TOP: mask_top_r <= wr_data;
               default: ;
            endcase
         end
         if (config_valid_r & (normal_mode | stop_mode)) begin
            if (bus_timeout_event)
               bus_timeout_flag <= 1'b1;
            else if (rd_en & wr_ctrl)
               bus_timeout_flag <= 1'b0;
         end
      end
   end

   always @* begin
      case (addr)
         `CSW_ADDR_CTRL:     rd_data = {calibration_enable_r, trim_unlock_r,
                                        bus_timeout_irq_enable_r, 3'h0, config_valid_r};
         `CSW_ADDR_BTQ:      rd_data = btq_r;
         `CSW_ADDR_SPC:      rd_data = {2'h0, spc_r};
         `CSW_ADDR_ID_TOP:   rd_data = id_top_r;
         `CSW_ADDR_ID_UMID:  rd_data = id_umid_r;
         `CSW_ADDR_ID_LMID:  rd_data = id_lmid_r;
         `CSW_ADDR_ID_BOT:   rd_data = {1'b0, id_bot_r};
         `CSW_ADDR_MASK_TOP: rd_data = mask_top_r;
         default:            rd_data = 8'h00;
      endcase
   end
endmodule // csw_config_bank

// file: verification/csw_config_bank_assertions.sv
// Purpose: Port assertions for the selective wake config bank
// Assumes: One clock, async high reset
// Notes:   Bound to the design below the endmodule
`timescale 1ns/100ps
module csw_chk (input wire clock, rst, soft_rst, wr_en, stop_mode, normal_mode, wake_event, irq,
   input wire [6:0] addr, input wire [7:0] wr_data, rd_data, input wire transceiver_tx_input,
   wake_option_wr, wake_option_wr_accept, calibration_active, trim_reference,
   selective_wake_en, bus_timeout_flag, cfg_clear_pulse);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_ctl; wr_en && !soft_rst && addr == 7'h20; endsequence
   AST_CAL: assert property (s_ctl |=> calibration_active ==
      ($past(wr_data[7]) && $past(wr_data[6:5]) == 2'h3)) else $error("cal");
   AST_OPT: assert property (s_ctl |=> wake_option_wr_accept ==
      (wake_option_wr && $past(wr_data[6:5]) == 2'h3)) else $error("opt");
   AST_REF: assert property (trim_reference ==
      (calibration_active && transceiver_tx_input)) else $error("ref");
   AST_IRQ: assert property (s_ctl |=> irq ==
      (bus_timeout_flag && $past(wr_data[4]))) else $error("irq");
   AST_TO: assert property ($rose(bus_timeout_flag) |->
      $past(selective_wake_en)) else $error("to");
   AST_MODE: assert property ($rose(bus_timeout_flag) |->
      $past(normal_mode || stop_mode)) else $error("mode");
   AST_SRST: assert property (soft_rst |=>
      !selective_wake_en && !bus_timeout_flag && !calibration_active) else $error("srst");
   AST_RSV: assert property (!(addr == 7'h20 && rd_data[3:1] != 0 ||
      addr == 7'h22 && rd_data[7:6] != 0 || addr == 7'h26 && rd_data[7])) else $error("rsv");
   AST_VAL: assert property (s_ctl ##0 (wr_data[0] && !stop_mode && !wake_event &&
      !cfg_clear_pulse) |=> selective_wake_en) else $error("val");
   AST_CLR: assert property (cfg_clear_pulse || wake_event |=>
      !selective_wake_en) else $error("clr");
   AST_PUL: assert property (wr_en && (addr > 7'h20 && addr < 7'h28 ||
      addr == 7'h20 && stop_mode) |-> cfg_clear_pulse) else $error("pul");
endmodule // csw_chk
bind csw_config_bank csw_chk chk_u (.*);

// file: verification/csw_host_model.sv
// Purpose: Host model that writes and reads the bank
// Assumes: Each write waits for a rising edge first
// Notes:   Write data is inverted once released
`timescale 1ns/100ps
module csw_host (input wire clock, input wire [7:0] rd_data, output reg wr_en,
   output reg [6:0] addr, output reg [7:0] wr_data);
   initial begin wr_en = 0; addr = 7'h20; wr_data = 8'h00; end
   task wr(input [6:0] a, input [7:0] d); begin
      @(posedge clock) #1 addr = a; wr_data = d; wr_en = 1;
      @(posedge clock) #1 wr_en = 0; wr_data = ~d;
   end endtask
   task rd(input [6:0] a, output [7:0] q); begin
      addr = a; #1 q = rd_data;
   end endtask
endmodule // csw_host

// file: verification/csw_config_bank_tb.sv
// Purpose: Self-checking bench for the selective wake config bank
// Assumes: Host model drives the write strobe
// Notes:   Seeded random writes plus valid-flag corner cases
`timescale 1ns/100ps
`define CHK(n,e,v) begin n_compared++; if ((v) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, v); end end
module csw_config_bank_tb;
   reg clock = 0, rst = 1, stop_mode = 0, normal_mode = 1, wake_event = 0;
   reg bus_timeout_event = 0, transceiver_tx_input = 0, cfg_write_other = 0, wake_option_wr = 1;
   reg soft_rst = 0, rd_en = 0;
   wire wr_en, wake_option_wr_accept, calibration_active, trim_reference, selective_wake_en;
   wire bus_timeout_flag, irq, expected_ide, expected_rtr, cfg_clear_pulse;
   wire [6:0] addr; wire [7:0] wr_data, rd_data, quanta_per_bit, id_mask_top;
   wire [5:0] sample_point_fraction; wire [28:0] expected_id;
   integer failures = 0, n_compared = 0, i; reg [7:0] q, d, sh [0:7]; reg [6:0] a;
   always #5 clock = ~clock;
   csw_host host_u (.clock(clock), .rd_data(rd_data), .wr_en(wr_en), .addr(addr),
      .wr_data(wr_data));
   csw_config_bank dut_u (.*);
   function [7:0] rmask(input [6:0] a, input [7:0] d);
      rmask = a == 7'h20 ? d & 8'hf1 : a == 7'h22 ? d & 8'h3f : a == 7'h26 ? d & 8'h7f :
         a > 7'h27 ? 8'h00 : d;
   endfunction
   task print_verdict; begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   end endtask
   initial begin #100000; failures++; print_verdict; end
   initial begin
      i = $urandom(62156);
      for (i = 0; i < 8; i++) sh[i] = i == 1 ? 8'ha0 : i == 2 ? 8'h33 : 8'h00;
      repeat (2) @(posedge clock); #1 rst = 0;
      for (i = 0; i < 9; i++) begin
         host_u.rd(7'h20 + i, q); `CHK("reset", rmask(7'h20 + i, i < 8 ? sh[i] : 0), q)
      end
      @(posedge clock) #1 bus_timeout_event = 1; @(posedge clock) #1 bus_timeout_event = 0;
      `CHK("flag", 1'b0, bus_timeout_flag)
      for (i = 0; i < 40; i++) begin
         a = 7'h20 + $urandom % 9; d = $urandom; d[0] = d[0] & (a != 7'h20);
         d[1] = d[1] & (a != 7'h26);
         stop_mode = $urandom; transceiver_tx_input = $urandom;
         host_u.wr(a, d); if (a < 7'h28) sh[a - 7'h20] = d;
         host_u.rd(a, q); `CHK("rdback", rmask(a, d), q)
         `CHK("cal", sh[0][7] && sh[0][6:5] == 2'h3, calibration_active)
         `CHK("ref", calibration_active && transceiver_tx_input, trim_reference)
         `CHK("opt", sh[0][6:5] == 2'h3, wake_option_wr_accept)
      end
      `CHK("id", {sh[3], sh[4], sh[5], sh[6][6:2]}, expected_id)
      `CHK("ide", sh[6][0], expected_ide)
      `CHK("rtr", sh[6][1], expected_rtr)
      `CHK("qpb", sh[1], quanta_per_bit)
      `CHK("spf", sh[2][5:0], sample_point_fraction)
      `CHK("mask", sh[7], id_mask_top)
      stop_mode = 0; host_u.wr(7'h20, 8'h71);
      @(posedge clock) #1 bus_timeout_event = 1; @(posedge clock) #1 bus_timeout_event = 0;
      `CHK("irq", 1'b1, irq)
      host_u.wr(7'h20, 8'h61); `CHK("masked", 1'b0, irq)
      rd_en = 1; host_u.wr(7'h20, 8'h61); rd_en = 0;
      `CHK("flagclr", 1'b0, bus_timeout_flag)
      normal_mode = 0;
      @(posedge clock) #1 bus_timeout_event = 1; @(posedge clock) #1 bus_timeout_event = 0;
      `CHK("modegate", 1'b0, bus_timeout_flag)
      normal_mode = 1;
      for (i = 1; i < 5; i++) begin
         stop_mode = 0; host_u.wr(7'h20, 8'h61); `CHK("valid", 1'b1, selective_wake_en)
         if (i < 3) begin
            @(posedge clock) #1 {wake_event, cfg_write_other} = i[1:0];
            @(posedge clock) #1 {wake_event, cfg_write_other} = 2'h0;
         end else begin stop_mode = i[0]; host_u.wr(i == 3 ? 7'h20 : 7'h24, 8'h61); end
         `CHK("cleared", 1'b0, selective_wake_en)
      end
      stop_mode = 0; host_u.wr(7'h21, 8'h5c); host_u.wr(7'h23, 8'h9e);
      @(posedge clock) #1 soft_rst = 1; @(posedge clock) #1 soft_rst = 0;
      `CHK("srst_qpb", 8'ha0, quanta_per_bit)
      `CHK("srst_spf", 6'h33, sample_point_fraction)
      `CHK("srst_id", 29'h0, expected_id)
      host_u.rd(7'h20, q); `CHK("srst_ctrl", 8'h00, q)
      print_verdict;
   end
endmodule // csw_config_bank_tb
